// ### plcct_pkg.sv
package plcct_pkg;

  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES     = TICK_MS * CLK_MHZ * 1000;
  localparam int unsigned COUNTS_PER_SEC  = 100;
  localparam int unsigned PCT_SCALE       = 100;
  localparam int unsigned NUM_STATEMENTS  = 30;
  localparam int unsigned NUM_TIMERS      = 4;

  localparam logic [7:0] OFS_A_SRC   = 8'h00;
  localparam logic [7:0] OFS_A_WIN   = 8'h04;
  localparam logic [7:0] OFS_B_SRC   = 8'h08;
  localparam logic [7:0] OFS_B_WIN   = 8'h0C;
  localparam logic [7:0] OFS_A_CTR   = 8'h10;
  localparam logic [7:0] OFS_B_CTR   = 8'h14;
  localparam logic [7:0] OFS_TMO0    = 8'h20;
  localparam logic [7:0] OFS_CNT0    = 8'h30;
  localparam logic [7:0] OFS_STATUS  = 8'h40;
  localparam logic [7:0] OFS_TRIPCLR = 8'h44;

  localparam logic [7:0] CODE_FALSE  = 8'h00;
  localparam logic [7:0] CODE_TRUE   = 8'h01;
  localparam logic [7:0] CODE_LAST   = 8'h1A;
  localparam logic [7:0] CODE_CMP_A  = 8'h4C;
  localparam logic [7:0] CODE_CMP_B  = 8'h4D;
  localparam logic [7:0] CODE_LT     = 8'h58;
  localparam logic [7:0] CODE_EQ     = 8'h59;
  localparam logic [7:0] CODE_GT     = 8'h5A;

  localparam int unsigned BIT_CMP_A  = 27;
  localparam int unsigned BIT_CMP_B  = 28;
  localparam int unsigned BIT_LT     = 29;
  localparam int unsigned BIT_EQ     = 30;
  localparam int unsigned BIT_GT     = 31;

  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT  = 16'hFFFF;

  typedef struct packed {
    logic signed [15:0] speed_meas;
    logic signed [15:0] speed_ref;
    logic signed [15:0] speed_demand;
    logic        [15:0] at_speed_band;
    logic        [15:0] min_output_speed;
    logic        [15:0] max_output_speed;
    logic               motor_i2t_over;
    logic               drive_i2t_over;
    logic               soft_start_done;
    logic               hw_enable;
    logic               error_present;
    logic               drive_ready;
    logic               pwm_active;
    logic               faulted;
    logic               motor_ot_trip;
  } plcct_drive_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } plcct_apb_req_t;

endpackage

// ### plcct_top.sv
`timescale 1ns/1ps
`default_nettype none

module plcct_top #(
  parameter int unsigned NPARAM      = 16,
  parameter int unsigned PW          = 16,
  parameter int unsigned TICK_CYCLES = plcct_pkg::TICK_CYCLES
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [NPARAM-1:0][PW-1:0]  param_value,
  input  wire logic [NPARAM-1:0][PW-1:0]  param_max,
  input  wire plcct_pkg::plcct_drive_t    drive,
  input  wire logic [7:0]                 cond_code,
  input  wire logic [3:0]                 timer_start,
  input  wire logic [3:0]                 timer_stop,
  output logic                            cond_result,
  output logic      [31:0]                cond_vec,
  output logic      [3:0]                 timer_done,
  output logic                            eval_tick,
  output logic                            stmt_valid,
  output logic      [4:0]                 stmt_index
);

  localparam int unsigned TCW = $clog2(TICK_CYCLES + 1);
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

  // ---------------- APB slave ----------------
  logic [7:0]  a_src_q, b_src_q;
  logic [7:0]  a_win_q, b_win_q;
  logic [7:0]  a_ctr_q, b_ctr_q;
  logic [3:0][15:0] tmo_q;
  logic [3:0][15:0] cnt_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  logic        trip_q;
  logic [31:0] cond_vec_q;
  logic [3:0]  done_q;

  wire logic access = psel && penable && !pready_q;
  wire logic wr_en  = access && pwrite;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= plcct_pkg::OFS_B_CTR && a[1:0] == 2'b00) ||
              (a >= plcct_pkg::OFS_TMO0 && a <= plcct_pkg::OFS_TRIPCLR &&
               a[1:0] == 2'b00);
  endfunction

  // one wait state keeps every bus output straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= plcct_pkg::RST_ZERO;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !addr_ok(paddr);
      prdata_q  <= plcct_pkg::RST_ZERO;
      if (access && !pwrite) begin
        case (paddr)
          plcct_pkg::OFS_A_SRC:  prdata_q <= {24'h000000, a_src_q};
          plcct_pkg::OFS_A_WIN:  prdata_q <= {24'h000000, a_win_q};
          plcct_pkg::OFS_B_SRC:  prdata_q <= {24'h000000, b_src_q};
          plcct_pkg::OFS_B_WIN:  prdata_q <= {24'h000000, b_win_q};
          plcct_pkg::OFS_A_CTR:  prdata_q <= {24'h000000, a_ctr_q};
          plcct_pkg::OFS_B_CTR:  prdata_q <= {24'h000000, b_ctr_q};
          plcct_pkg::OFS_STATUS: prdata_q <= cond_vec_q;
          plcct_pkg::OFS_TRIPCLR:
            prdata_q <= {27'h0000000, done_q, trip_q};
          default: begin
            if (paddr >= plcct_pkg::OFS_TMO0 && paddr < plcct_pkg::OFS_CNT0)
              prdata_q <= {16'h0000, tmo_q[paddr[3:2]]};
            else if (paddr >= plcct_pkg::OFS_CNT0 &&
                     paddr < plcct_pkg::OFS_STATUS)
              prdata_q <= {16'h0000, cnt_q[paddr[3:2]]};
          end
        endcase
      end
    end
  end

  // comparator configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_src_q <= 8'h00;
      b_src_q <= 8'h00;
      a_win_q <= 8'h00;
      b_win_q <= 8'h00;
      a_ctr_q <= 8'h00;
      b_ctr_q <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        plcct_pkg::OFS_A_SRC: a_src_q <= pwdata[7:0];
        plcct_pkg::OFS_A_WIN: a_win_q <= pwdata[7:0];
        plcct_pkg::OFS_B_SRC: b_src_q <= pwdata[7:0];
        plcct_pkg::OFS_B_WIN: b_win_q <= pwdata[7:0];
        plcct_pkg::OFS_A_CTR: a_ctr_q <= pwdata[7:0];
        plcct_pkg::OFS_B_CTR: b_ctr_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------- 10 ms evaluation tick ----------------
  logic [TCW-1:0] tick_cnt_q;
  logic           tick_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      if (tick_cnt_q == TICK_LAST)
        tick_cnt_q <= '0;
      else
        tick_cnt_q <= tick_cnt_q + TCW'(1);
    end
  end

  // statement slots walk 0..29 after each tick, one per cycle
  logic       stmt_valid_q;
  logic [4:0] stmt_index_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stmt_valid_q <= 1'b0;
      stmt_index_q <= 5'h00;
    end else if (tick_q) begin
      stmt_valid_q <= 1'b1;
      stmt_index_q <= 5'h00;
    end else if (stmt_valid_q) begin
      if (stmt_index_q == 5'(plcct_pkg::NUM_STATEMENTS - 1)) begin
        stmt_valid_q <= 1'b0;
      end else begin
        stmt_index_q <= stmt_index_q + 5'h01;
      end
    end
  end

  // ---------------- timers ----------------
  // count is in hundredths of a second; all ones means stopped
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_timer
      wire logic wr_tmo = wr_en &&
        paddr == plcct_pkg::OFS_TMO0 + 8'(4 * gi);
      wire logic wr_cnt = wr_en &&
        paddr == plcct_pkg::OFS_CNT0 + 8'(4 * gi);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          tmo_q[gi] <= 16'h0000;
        else if (wr_tmo)
          tmo_q[gi] <= pwdata[15:0];
      end

      // a software write overrides a same-cycle start or stop action
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[gi] <= plcct_pkg::RST_COUNT;
        end else if (wr_cnt) begin
          cnt_q[gi] <= pwdata[15:0];
        end else if (timer_stop[gi]) begin
          cnt_q[gi] <= plcct_pkg::RST_COUNT;
        end else if (timer_start[gi]) begin
          cnt_q[gi] <= 16'h0000;
        end else if (tick_q && cnt_q[gi] != plcct_pkg::RST_COUNT &&
                     cnt_q[gi] < tmo_q[gi]) begin
          cnt_q[gi] <= cnt_q[gi] + 16'h0001;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          done_q[gi] <= 1'b0;
        else
          done_q[gi] <= cnt_q[gi] != plcct_pkg::RST_COUNT &&
                        cnt_q[gi] >= tmo_q[gi];
      end
    end
  endgenerate

  // ---------------- comparators ----------------
  // normalized compares are done by cross-multiplying, so no divider;
  // a source index past the bank (or a non-positive max) reads false,
  // which is also where a circular self-pointer would land
  function automatic logic signed [33:0] clamp_val(
      input logic [PW-1:0] v, input logic [PW-1:0] m);
    logic signed [33:0] sv;
    logic signed [33:0] sm;
    sv = 34'(signed'(v));
    sm = 34'(signed'(m));
    if (sv > sm)
      clamp_val = sm;
    else if (sv < -sm)
      clamp_val = -sm;
    else
      clamp_val = sv;
  endfunction

  function automatic logic window_hit(
      input logic signed [33:0] v, input logic signed [33:0] m,
      input logic [7:0] ctr, input logic [7:0] win);
    logic signed [33:0] diff;
    logic signed [33:0] lim;
    diff = 34'(v * 34'(plcct_pkg::PCT_SCALE)) -
           34'(34'(signed'(ctr)) * m);
    lim  = 34'({26'h0000000, win} * m);
    if (diff < 0)
      diff = -diff;
    window_hit = diff <= lim;
  endfunction

  logic               a_ok, b_ok;
  logic signed [33:0] va, vb, ma, mb, xa, xb;

  always_comb begin
    a_ok = 32'(a_src_q) < NPARAM;
    b_ok = 32'(b_src_q) < NPARAM;
    va = '0;
    vb = '0;
    ma = '0;
    mb = '0;
    if (a_ok) begin
      ma = 34'(signed'(param_max[a_src_q]));
      va = clamp_val(param_value[a_src_q], param_max[a_src_q]);
    end
    if (b_ok) begin
      mb = 34'(signed'(param_max[b_src_q]));
      vb = clamp_val(param_value[b_src_q], param_max[b_src_q]);
    end
    a_ok = a_ok && ma > 0;
    b_ok = b_ok && mb > 0;
    xa = 34'(va * mb);
    xb = 34'(vb * ma);
  end

  // ---------------- condition vector, sampled on each tick ----------------
  logic signed [16:0] spd_err, spd_abs;

  always_comb begin
    spd_err = 17'(drive.speed_meas) - 17'(drive.speed_ref);
    if (spd_err < 0)
      spd_err = -spd_err;
    spd_abs = 17'(drive.speed_meas);
    if (spd_abs < 0)
      spd_abs = -spd_abs;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      trip_q <= 1'b0;
    else if (drive.motor_ot_trip)
      trip_q <= 1'b1;
    else if (wr_en && paddr == plcct_pkg::OFS_TRIPCLR && pwdata[0])
      trip_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_vec_q <= plcct_pkg::RST_ZERO;
    end else if (tick_q) begin
      cond_vec_q <= plcct_pkg::RST_ZERO;
      cond_vec_q[1]  <= 1'b1;
      cond_vec_q[14] <= spd_err <= 17'(drive.at_speed_band);
      cond_vec_q[16] <= spd_abs < 17'(drive.min_output_speed);
      cond_vec_q[17] <= spd_abs > 17'(drive.max_output_speed);
      cond_vec_q[19] <= drive.motor_i2t_over;
      cond_vec_q[20] <= drive.drive_i2t_over;
      cond_vec_q[21] <= drive.speed_meas > 0;
      cond_vec_q[22] <= drive.speed_demand > 0;
      cond_vec_q[23] <= drive.soft_start_done && drive.hw_enable &&
                        !drive.error_present;
      cond_vec_q[24] <= drive.drive_ready && drive.pwm_active;
      cond_vec_q[25] <= drive.faulted;
      cond_vec_q[26] <= trip_q || drive.motor_ot_trip;
      cond_vec_q[plcct_pkg::BIT_CMP_A] <=
        a_ok && window_hit(va, ma, a_ctr_q, a_win_q);
      cond_vec_q[plcct_pkg::BIT_CMP_B] <=
        b_ok && window_hit(vb, mb, b_ctr_q, b_win_q);
      cond_vec_q[plcct_pkg::BIT_LT] <= a_ok && b_ok && xa < xb;
      cond_vec_q[plcct_pkg::BIT_EQ] <= a_ok && b_ok && xa == xb;
      cond_vec_q[plcct_pkg::BIT_GT] <= a_ok && b_ok && xa > xb;
    end
  end

  // ---------------- condition code decoder ----------------
  function automatic logic cond_lookup(
      input logic [7:0] code, input logic [31:0] v);
    if (code <= plcct_pkg::CODE_LAST)
      cond_lookup = v[code[4:0]];
    else if (code == plcct_pkg::CODE_CMP_A)
      cond_lookup = v[plcct_pkg::BIT_CMP_A];
    else if (code == plcct_pkg::CODE_CMP_B)
      cond_lookup = v[plcct_pkg::BIT_CMP_B];
    else if (code == plcct_pkg::CODE_LT)
      cond_lookup = v[plcct_pkg::BIT_LT];
    else if (code == plcct_pkg::CODE_EQ)
      cond_lookup = v[plcct_pkg::BIT_EQ];
    else if (code == plcct_pkg::CODE_GT)
      cond_lookup = v[plcct_pkg::BIT_GT];
    else
      cond_lookup = 1'b0;
  endfunction

  logic cond_result_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cond_result_q <= 1'b0;
    else
      cond_result_q <= cond_lookup(cond_code, cond_vec_q);
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign cond_result = cond_result_q;
  assign cond_vec    = cond_vec_q;
  assign timer_done  = done_q;
  assign eval_tick   = tick_q;
  assign stmt_valid  = stmt_valid_q;
  assign stmt_index  = stmt_index_q;

  // ---------------- assertions ----------------
  a_code_zero_false: assert property (@(posedge pclk) disable iff (!presetn)
    cond_code == plcct_pkg::CODE_FALSE |=> !cond_result_q)
    else $error("code 0 did not read false");

  a_code_one_true: assert property (@(posedge pclk) disable iff (!presetn)
    cond_code == plcct_pkg::CODE_TRUE && $past(tick_q) |=> cond_result_q)
    else $error("code 1 did not read true");

  a_reserved_false: assert property (@(posedge pclk) disable iff (!presetn)
    (cond_code == 8'h12 || cond_code == 8'h1B || cond_code == 8'h57)
    |=> !cond_result_q)
    else $error("reserved code read true");

  a_relation_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $past(tick_q) && $past(a_ok && b_ok) |->
    $onehot(cond_vec_q[plcct_pkg::BIT_GT:plcct_pkg::BIT_LT]))
    else $error("less/equal/greater not exclusive");

  a_timer_start: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == plcct_pkg::OFS_CNT0 && pwdata[15:0] == 16'h0000
    |=> cnt_q[0] == 16'h0000)
    else $error("write of zero did not start timer");

  a_timer_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_q[1] == plcct_pkg::RST_COUNT && !wr_en && !timer_start[1]
    |=> cnt_q[1] == plcct_pkg::RST_COUNT)
    else $error("stopped timer moved");

  a_timer_step: assert property (@(posedge pclk) disable iff (!presetn)
    !tick_q && !wr_en && timer_start == 4'h0 && timer_stop == 4'h0
    |=> $stable(cnt_q))
    else $error("timer moved without a tick");

  a_stmt_walk: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |=> stmt_valid_q && stmt_index_q == 5'h00 ##29
    stmt_valid_q && stmt_index_q == 5'h1D ##1 !stmt_valid_q)
    else $error("statement walk out of order");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("ready not a single cycle");

  c_cmp_a_true: cover property (@(posedge pclk) disable iff (!presetn)
    cond_vec_q[plcct_pkg::BIT_CMP_A]);
  c_timer_done: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(done_q[0]));
  c_lt_seen: cover property (@(posedge pclk) disable iff (!presetn)
    cond_vec_q[plcct_pkg::BIT_LT]);
  c_apb_error: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr_q);

endmodule

`default_nettype wire

// ### tb_plcct_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_plcct_top;
  localparam int unsigned TICK = 40;
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [15:0][15:0]       param_value;
  logic [15:0][15:0]       param_max;
  plcct_pkg::plcct_drive_t drive;
  logic [7:0]              cond_code;
  logic [3:0]              timer_start;
  logic [3:0]              timer_stop;
  logic                    cond_result;
  logic [31:0]             cond_vec;
  logic [3:0]              timer_done;
  logic                    eval_tick;
  logic                    stmt_valid;
  logic [4:0]              stmt_index;
  int                      failures;
  int                      cmp_count;
  logic [31:0]             rd;
  logic                    err;
  logic                    trip_seen;
  int                      sa, sb, wa, wb, ca, cb, n, t;

  plcct_top #(.NPARAM(16), .PW(16), .TICK_CYCLES(TICK)) i_plcct_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .param_value(param_value),
    .param_max(param_max), .drive(drive), .cond_code(cond_code),
    .timer_start(timer_start), .timer_stop(timer_stop),
    .cond_result(cond_result), .cond_vec(cond_vec),
    .timer_done(timer_done), .eval_tick(eval_tick),
    .stmt_valid(stmt_valid), .stmt_index(stmt_index));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // returns one edge after the tick edge, so cond_vec is fresh
  task automatic wait_tick();
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (eval_tick !== 1'b1 && k < 4 * TICK);
    @(posedge pclk);
    #1;
  endtask

  function automatic int clampv(int v, int m);
    return (v > m) ? m : ((v < -m) ? -m : v);
  endfunction

  // cross-multiplied so no division rounding creeps in
  function automatic logic inwin(int v, int m, int c, int w);
    return ((100 * v - c * m) <= w * m) && ((c * m - 100 * v) <= w * m);
  endfunction

  function automatic logic [31:0] exp_vec();
    logic [31:0] e;
    int va, ma, vb, mb, sm, asm, df;
    ma = int'(param_max[sa]);
    mb = int'(param_max[sb]);
    va = clampv(int'($signed(param_value[sa])), ma);
    vb = clampv(int'($signed(param_value[sb])), mb);
    sm = int'(drive.speed_meas);
    asm = (sm < 0) ? -sm : sm;
    df = sm - int'(drive.speed_ref);
    e = 32'h0000_0002;
    e[14] = ((df < 0) ? -df : df) <= int'(drive.at_speed_band);
    e[16] = asm < int'(drive.min_output_speed);
    e[17] = asm > int'(drive.max_output_speed);
    e[19] = drive.motor_i2t_over;
    e[20] = drive.drive_i2t_over;
    e[21] = sm > 0;
    e[22] = int'(drive.speed_demand) > 0;
    e[23] = drive.soft_start_done & drive.hw_enable & ~drive.error_present;
    e[24] = drive.drive_ready & drive.pwm_active;
    e[25] = drive.faulted;
    e[26] = trip_seen;
    e[27] = inwin(va, ma, ca, wa);
    e[28] = inwin(vb, mb, cb, wb);
    e[29] = va * mb < vb * ma;
    e[30] = va * mb == vb * ma;
    e[31] = va * mb > vb * ma;
    return e;
  endfunction

  function automatic logic code_exp(int c, logic [31:0] e);
    case (c)
      76: return e[27];
      77: return e[28];
      88: return e[29];
      89: return e[30];
      90: return e[31];
      default: return (c <= 26) ? e[c] : 1'b0;
    endcase
  endfunction

  task automatic setup(input int k);
    logic [127:0]            r;
    plcct_pkg::plcct_drive_t d;
    for (int i = 0; i < 16; i++) begin
      param_max[i] <= (k == 0 && i == 0) ? 16'h0064
                      : 16'($urandom_range(1000, 1));
      param_value[i] <= (k == 0 && i == 0) ? 16'h0014
                        : 16'($urandom_range(2200, 0) - 1100);
    end
    r = {$urandom, $urandom, $urandom, $urandom};
    d = r[$bits(d)-1:0];
    d.motor_ot_trip = 1'b0;
    drive <= d;
    sa = (k == 0) ? 0 : int'($urandom_range(15, 0));
    sb = (k < 2) ? sa : int'($urandom_range(15, 0));
    wa = (k == 0) ? 20 : int'($urandom_range(120, 0));
    wb = (k == 0) ? 19 : int'($urandom_range(120, 0));
    ca = (k == 0) ? 0 : int'($urandom_range(200, 0)) - 100;
    cb = (k == 0) ? 0 : int'($urandom_range(200, 0)) - 100;
    apb(1'b1, plcct_pkg::OFS_A_SRC, 32'(sa));
    apb(1'b1, plcct_pkg::OFS_A_WIN, 32'(wa));
    apb(1'b1, plcct_pkg::OFS_B_SRC, 32'(sb));
    apb(1'b1, plcct_pkg::OFS_B_WIN, 32'(wb));
    apb(1'b1, plcct_pkg::OFS_A_CTR, {24'h0, 8'(ca)});
    apb(1'b1, plcct_pkg::OFS_B_CTR, {24'h0, 8'(cb)});
    apb(1'b0, plcct_pkg::OFS_A_WIN, 32'h0);
    chk("window readback", rd, 32'(wa));
  endtask

  task automatic check_conds();
    logic [31:0] e;
    wait_tick();
    e = exp_vec();
    chk("cond_vec", cond_vec, e);
    apb(1'b0, plcct_pkg::OFS_STATUS, 32'h0);
    chk("status", rd, e);
    for (int c = 0; c < 96; c++) begin
      cond_code <= 8'(c);
      repeat (2) @(posedge pclk);
      chk("cond_result", {31'h0, cond_result}, {31'h0, code_exp(c, e)});
    end
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    results();
  end

  initial begin
    void'($urandom(15096));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    param_value = '0;
    param_max = '0;
    drive = '0;
    cond_code = 8'h00;
    timer_start = 4'h0;
    timer_stop = 4'h0;
    failures = 0;
    cmp_count = 0;
    trip_seen = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, plcct_pkg::OFS_STATUS, 32'h0);
    chk("status reset", rd, plcct_pkg::RST_ZERO);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("config reset", rd, plcct_pkg::RST_ZERO);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(plcct_pkg::OFS_TMO0 + 4 * i), 32'h0);
      chk("timeout reset", rd, plcct_pkg::RST_ZERO);
      apb(1'b0, 8'(plcct_pkg::OFS_CNT0 + 4 * i), 32'h0);
      chk("count reset", rd, {16'h0, plcct_pkg::RST_COUNT});
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    for (int k = 0; k < 6; k++) begin
      setup(k);
      check_conds();
    end
    // sticky trip: a one-cycle pulse must be remembered until cleared
    drive.motor_ot_trip <= 1'b1;
    @(posedge pclk);
    drive.motor_ot_trip <= 1'b0;
    trip_seen = 1'b1;
    wait_tick();
    chk("trip set", 32'(cond_vec[26]), 32'h1);
    apb(1'b1, plcct_pkg::OFS_TRIPCLR, 32'h1);
    trip_seen = 1'b0;
    wait_tick();
    chk("trip cleared", 32'(cond_vec[26]), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wait_tick();
      apb(1'b1, 8'(plcct_pkg::OFS_TMO0 + 4 * i), 32'(i + 2));
      apb(1'b1, 8'(plcct_pkg::OFS_CNT0 + 4 * i), 32'h0);
      n = 0;
      t = 0;
      while (timer_done[i] !== 1'b1 && t < 10 * TICK) begin
        @(posedge pclk);
        if (eval_tick === 1'b1) n++;
        t++;
      end
      chk("ticks to done", 32'(n), 32'(i + 2));
      apb(1'b0, 8'(plcct_pkg::OFS_CNT0 + 4 * i), 32'h0);
      chk("count at timeout", rd, 32'(i + 2));
    end
    wait_tick();
    timer_start <= 4'h1;
    @(posedge pclk);
    timer_start <= 4'h0;
    apb(1'b0, plcct_pkg::OFS_CNT0, 32'h0);
    chk("count after start", rd, 32'h0);
    timer_stop <= 4'h1;
    @(posedge pclk);
    timer_stop <= 4'h0;
    apb(1'b1, 8'(plcct_pkg::OFS_CNT0 + 4), 32'h0000_FFFF);
    wait_tick();
    apb(1'b0, plcct_pkg::OFS_CNT0, 32'h0);
    chk("count after stop", rd, 32'h0000_FFFF);
    apb(1'b0, 8'(plcct_pkg::OFS_CNT0 + 4), 32'h0);
    chk("count written max", rd, 32'h0000_FFFF);
    chk("done when stopped", 32'(timer_done[1:0]), 32'h0);
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (eval_tick !== 1'b1 && t < 4 * TICK);
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (stmt_valid !== 1'b1 && t < 4);
    for (int k = 0; k < 30; k++) begin
      chk("stmt walk", {26'h0, stmt_valid, stmt_index}, 32'(32 + k));
      @(posedge pclk);
      t++;
    end
    chk("stmt end", 32'(stmt_valid), 32'h0);
    while (eval_tick !== 1'b1 && t < 4 * TICK) begin
      @(posedge pclk);
      t++;
    end
    chk("tick period", 32'(t), 32'(TICK));
    results();
  end
endmodule

`default_nettype wire
